// ### rtl/root_port_pkg.sv
// Purpose: shared constants and types for the root port status block
// Assumes: 40 MHz system clock, APB with 32-bit data
// Notes: offsets are byte addresses of aligned words
package root_port_pkg;
    // ==========================================================
    // register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] PORT_OFF = 12'h000;
    localparam logic [11:0] INT_STAT_OFF = 12'h004;
    localparam logic [11:0] INT_MASK_OFF = 12'h008;
    localparam logic [11:0] CFG_OFF = 12'h00c;
    // ==========================================================
    // port register fields
    localparam int CCS_BIT = 0;
    localparam int SPE_BIT = 1;
    localparam int SPS_BIT = 2;
    localparam int RESET_STAT_BIT = 4;
    localparam int POWER_BIT = 8;
    localparam int LOW_SPEED_BIT = 9;
    localparam int CONN_CHANGE_BIT = 16;
    // ==========================================================
    // interrupt and configuration fields
    localparam int EV_CONN_BIT = 0;
    localparam int EV_RST_BIT = 1;
    localparam int EV_W = 2;
    localparam int NONREM_BIT = 0;
    localparam int HUB_RST_BIT = 1;
    // ==========================================================
    // values after reset
    localparam logic POWER_RST = 1'b0;
    localparam logic CONN_CHANGE_RST = 1'b0;
    localparam logic NONREM_RST = 1'b0;
    localparam logic [1:0] EV_RST_VAL = 2'h0;
    localparam logic [1:0] MASK_RST_VAL = 2'h0;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int RESET_TIME_US = 10;
    localparam int RESET_CYCLES = RESET_TIME_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 20;
    // ==========================================================
    // port reset signalling states
    typedef enum logic [1:0] {
        RST_IDLE = 2'b01,
        RST_DRIVE = 2'b10
    } rst_state_t;
endpackage

// ### rtl/pin_sync3.sv
// Purpose: bring an asynchronous pin into the system clock domain
// Assumes: pin may change at any time
// Notes: output moves only once the second and third stages agree
module pin_sync3 (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pin and clean level
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    // ==========================================================
    // three stage chain; first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // accept a change only when two late stages agree, filtering one-cycle glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end
endmodule

// ### rtl/port_reset_timer.sv
// Purpose: time the length of reset signalling on the port
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes: done pulses in the last busy cycle, the one before busy falls
module port_reset_timer #(
    parameter int CYCLES = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    import root_port_pkg::*;
    logic [CNT_W-1:0] cnt_reg;
    // ==========================================================
    // down counter; busy while nonzero
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else if (start_i && cnt_reg == '0) begin
            cnt_reg <= CNT_W'(CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end
    assign busy_o = (cnt_reg != '0);
    assign done_o = (cnt_reg == CNT_W'(1));
endmodule

// ### rtl/root_port_ctrl.sv
// Purpose: status and control for root hub port 1 (connect change,
//          speed, power tracking, reset signalling) behind APB
// Assumes: connect and speed pins are asynchronous to the clock
// Notes: zero wait state slave; unmapped addresses answer pslverr
// ==========================================================
// Behaviour
// - a change of the port's connect status sets the connect change flag.
// - a set-reset, set-enable or set-suspend write while disconnected sets the connect change flag instead.
// - bit 9 reads 1 for a low-speed device and 0 for full speed, meaningful only while connected.
// - writing 1 to bit 9 clears the power state bit, writing 0 changes nothing.
// - writing 1 to bit 8 sets the power state bit, writing 0 leaves it.
// - bit 8 reads 1 while power is marked enabled and 0 while disabled.
// - the power state bit only tracks state for software and drives no output.
// - writing 1 to bit 4 sets the reset status bit and starts reset signalling, 0 does nothing.
// - writing 1 to the connect change flag clears it, writing 0 leaves it.
// - with a nonremovable device connect changes do not set the connect change flag; a root hub reset does.
// - the reset status bit reads 1 exactly while reset signalling is driven.
module root_port_ctrl
    import root_port_pkg::*;
#(
    parameter int RESET_CYC = RESET_CYCLES
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [root_port_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // port pins
    input wire logic DEV_CONNECT_I,
    input wire logic DEV_LOW_SPEED_I,
    output logic USB_RESET_O,
    // interrupt
    output logic IRQ_O
);
    import root_port_pkg::*;

    // ==========================================================
    // declarations
    logic rst_s1_reg;
    logic rst_n;
    logic ccs;
    logic ls_pin;
    logic ccs_prev_reg;
    logic conn_edge;
    logic setup;
    logic access;
    logic hit_port;
    logic hit_stat;
    logic hit_mask;
    logic hit_cfg;
    logic mapped;
    logic wr;
    logic wr_port;
    logic wr_stat;
    logic wr_mask;
    logic wr_cfg;
    logic set_req_any;
    logic reset_req_wr;
    logic reset_start;
    logic timer_busy;
    logic timer_done;
    logic hub_reset;
    logic conn_change_set;
    logic conn_change_clr;
    logic power_state_bit_reg;
    logic connect_change_flag_reg;
    logic nonremovable_device_mask_reg;
    logic hub_reset_seen_reg;
    logic [EV_W-1:0] ev_stat_reg;
    logic [EV_W-1:0] ev_mask_reg;
    logic [EV_W-1:0] ev_set;
    logic [31:0] port_view;
    logic [31:0] rd_next;
    rst_state_t rst_state_reg;

    // ==========================================================
    // reset release through two flip-flops
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    // ==========================================================
    // pin synchronisers
    // connect level; glitches shorter than two cycles are dropped
    pin_sync3 u_sync_conn (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .pin_i(DEV_CONNECT_I),
        .level_o(ccs)
    );

    // speed level of the attached device
    pin_sync3 u_sync_ls (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .pin_i(DEV_LOW_SPEED_I),
        .level_o(ls_pin)
    );

    // ==========================================================
    // connect edge detection on the clean level
    // previous level resets to the idle pin level, so no false edge follows reset
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ccs_prev_reg <= 1'b0;
        end else begin
            ccs_prev_reg <= ccs;
        end
    end
    assign conn_edge = ccs ^ ccs_prev_reg;

    // ==========================================================
    // apb decode
    // zero wait states, so ready is constant high
    // addresses are compared in full, so unaligned offsets are unmapped
    assign setup = PSEL_I & ~PENABLE_I;
    assign access = PSEL_I & PENABLE_I;
    assign hit_port = (PADDR_I == PORT_OFF);
    assign hit_stat = (PADDR_I == INT_STAT_OFF);
    assign hit_mask = (PADDR_I == INT_MASK_OFF);
    assign hit_cfg = (PADDR_I == CFG_OFF);
    assign mapped = hit_port | hit_stat | hit_mask | hit_cfg;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = access & ~mapped;

    // write strobes fire only on the completing edge of a mapped access
    assign wr = access & PWRITE_I & mapped;
    assign wr_port = wr & hit_port;
    assign wr_stat = wr & hit_stat;
    assign wr_mask = wr & hit_mask;
    assign wr_cfg = wr & hit_cfg;

    // ==========================================================
    // port register write decode
    // any of the three set requests while disconnected
    assign set_req_any = PWDATA_I[RESET_STAT_BIT] | PWDATA_I[SPE_BIT] | PWDATA_I[SPS_BIT];
    assign reset_req_wr = wr_port & PWDATA_I[RESET_STAT_BIT];
    // reset only starts on a connected port and not while already driving;
    // the timer is checked as well, so the state and the counter can
    // never fall out of step
    assign reset_start = reset_req_wr & ccs & (rst_state_reg == RST_IDLE) & ~timer_busy;

    // ==========================================================
    // port power tracking
    // clear wins over set when both are written together, matching
    // the usual software sequence of turning power off
    // pure bookkeeping: software may set it with nothing attached
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            power_state_bit_reg <= POWER_RST;
        end else if (wr_port && PWDATA_I[LOW_SPEED_BIT]) begin
            power_state_bit_reg <= 1'b0;
        end else if (wr_port && PWDATA_I[POWER_BIT]) begin
            power_state_bit_reg <= 1'b1;
        end
    end
    // the power bit feeds only the read path; no port power output exists

    // ==========================================================
    // reset signalling state machine
    // both codes are legal, so the case has no default
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            rst_state_reg <= RST_IDLE;
        end else begin
            unique case (rst_state_reg)
                RST_IDLE: begin
                    if (reset_start) begin
                        rst_state_reg <= RST_DRIVE;
                    end
                end
                RST_DRIVE: begin
                    if (timer_done) begin
                        rst_state_reg <= RST_IDLE;
                    end
                end
            endcase
        end
    end

    // length of the reset pulse
    // the timer ignores start while busy, a second guard behind the state check
    port_reset_timer #(
        .CYCLES(RESET_CYC)
    ) u_rst_timer (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .start_i(reset_start),
        .busy_o(timer_busy),
        .done_o(timer_done)
    );

    // line driven exactly while in the drive state
    assign USB_RESET_O = (rst_state_reg == RST_DRIVE);

    // ==========================================================
    // configuration: nonremovable marker and root hub reset command
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            nonremovable_device_mask_reg <= NONREM_RST;
        end else if (wr_cfg) begin
            nonremovable_device_mask_reg <= PWDATA_I[NONREM_BIT];
        end
    end
    // writing one to the command bit is a root hub reset pulse
    // the pulse lasts one cycle and needs no clear
    assign hub_reset = wr_cfg & PWDATA_I[HUB_RST_BIT];

    // remember that a root hub reset has happened since power-up
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            hub_reset_seen_reg <= 1'b0;
        end else if (hub_reset) begin
            hub_reset_seen_reg <= 1'b1;
        end
    end

    // ==========================================================
    // connect change flag
    // removable port: each attach or detach; nonremovable: only the
    // root hub reset announces the device, later edges are ignored
    // a set request written while disconnected still raises the flag
    always_comb begin
        conn_change_set = 1'b0;
        if (nonremovable_device_mask_reg) begin
            conn_change_set = hub_reset;
        end else begin
            conn_change_set = conn_edge;
        end
        if (wr_port && set_req_any && !ccs) begin
            conn_change_set = 1'b1;
        end
    end
    assign conn_change_clr = wr_port & PWDATA_I[CONN_CHANGE_BIT];

    // set wins over a clear in the same cycle so no event is lost;
    // software that clears must reread to catch such a collision
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            connect_change_flag_reg <= CONN_CHANGE_RST;
        end else if (conn_change_set) begin
            connect_change_flag_reg <= 1'b1;
        end else if (conn_change_clr) begin
            connect_change_flag_reg <= 1'b0;
        end
    end

    // ==========================================================
    // interrupt status, mask and output
    always_comb begin
        ev_set = '0;
        ev_set[EV_CONN_BIT] = conn_change_set;
        ev_set[EV_RST_BIT] = timer_done;
    end

    // sticky bits, write one to clear, set wins
    genvar gi;
    generate
        for (gi = 0; gi < EV_W; gi++) begin : g_ev
            always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
                if (!rst_n) begin
                    ev_stat_reg[gi] <= EV_RST_VAL[gi];
                end else if (ev_set[gi]) begin
                    ev_stat_reg[gi] <= 1'b1;
                end else if (wr_stat && PWDATA_I[gi]) begin
                    ev_stat_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // mask: one enables the event onto the interrupt line
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            ev_mask_reg <= MASK_RST_VAL;
        end else if (wr_mask) begin
            ev_mask_reg <= PWDATA_I[EV_W-1:0];
        end
    end

    // level interrupt, registered to keep it glitch free
    // costs one cycle of latency behind the status bit
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(ev_stat_reg & ev_mask_reg);
        end
    end

    // ==========================================================
    // read view of the port register
    // unlisted bits stay zero, writes to them have no target except the set requests in bits 1 and 2
    always_comb begin
        port_view = '0;
        port_view[CCS_BIT] = ccs;
        port_view[RESET_STAT_BIT] = (rst_state_reg == RST_DRIVE);
        port_view[POWER_BIT] = power_state_bit_reg;
        // speed only means something while connected
        port_view[LOW_SPEED_BIT] = ls_pin & ccs;
        // the change flag is the only live bit above the low half
        port_view[CONN_CHANGE_BIT] = connect_change_flag_reg;
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rd_next = '0;
        if (hit_port) begin
            rd_next = port_view;
        end else if (hit_stat) begin
            rd_next[EV_W-1:0] = ev_stat_reg;
        end else if (hit_mask) begin
            rd_next[EV_W-1:0] = ev_mask_reg;
        end else if (hit_cfg) begin
            rd_next[NONREM_BIT] = nonremovable_device_mask_reg;
            rd_next[HUB_RST_BIT] = hub_reset_seen_reg;
        end
    end

    // ==========================================================
    // read data register
    // captured in the setup cycle and held through access, so the
    // value is a flip-flop output; a flag set in the access cycle
    // shows on the next read
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA_O <= '0;
        end else if (setup && !PWRITE_I) begin
            PRDATA_O <= rd_next;
        end
    end

endmodule

// ### tb/root_port_checker.sv
// Purpose: port-level assertions for the root port status block
// Assumes: zero wait state apb, read data loaded at the setup edge
// Notes: connect pin stability is counted here to know when the port is settled
module root_port_checker
    import root_port_pkg::*;
#(
    parameter int RESET_CYC = 8
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RST_B_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [root_port_pkg::ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // port pins and interrupt
    input wire logic DEV_CONNECT_I,
    input wire logic DEV_LOW_SPEED_I,
    input wire logic USB_RESET_O,
    input wire logic IRQ_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_B_I);
    // ==========================================================
    // helpers
    logic wr_port, rd_port, rst_req, hub_req, conn_q, pwr_m, pwr_ok;
    logic [3:0] stab_cnt;
    int hi_cnt;
    assign wr_port = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == PORT_OFF;
    assign rd_port = PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == PORT_OFF;
    assign rst_req = wr_port && PWDATA_I[RESET_STAT_BIT];
    assign hub_req = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == CFG_OFF && PWDATA_I[HUB_RST_BIT];
    // settle count, so pin sync delay never makes a check fire early
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            conn_q <= 1'b0;
            stab_cnt <= 4'h0;
        end else begin
            conn_q <= DEV_CONNECT_I;
            if (DEV_CONNECT_I != conn_q) stab_cnt <= 4'h0;
            else if (stab_cnt != 4'hf) stab_cnt <= stab_cnt + 4'h1;
        end
    end
    // power model; a hub reset may touch it, so checking pauses until rewritten
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            pwr_m <= POWER_RST;
            pwr_ok <= 1'b1;
        end else if (wr_port && (PWDATA_I[LOW_SPEED_BIT] || PWDATA_I[POWER_BIT])) begin
            pwr_m <= !PWDATA_I[LOW_SPEED_BIT];
            pwr_ok <= 1'b1;
        end else if (hub_req) pwr_ok <= 1'b0;
    end
    always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
        if (!RST_B_I) hi_cnt <= 0;
        else hi_cnt <= USB_RESET_O ? hi_cnt + 1 : 0;
    end
    // ==========================================================
    // assertions
    rst_cause_a: assert property ($rose(USB_RESET_O) |-> $past(rst_req) || $past(hub_req))
        else $error("reset signalling began without a request");
    rst_go_a: assert property (rst_req && DEV_CONNECT_I && stab_cnt > 4'h7 && !USB_RESET_O |=> USB_RESET_O)
        else $error("reset request while connected did not start signalling");
    disc_noreset_a: assert property (rst_req && !DEV_CONNECT_I && stab_cnt > 4'h7 |=> !USB_RESET_O[*2])
        else $error("reset started on a disconnected port");
    rst_len_a: assert property ($fell(USB_RESET_O) |-> hi_cnt == RESET_CYC)
        else $error("reset signalling length wrong");
    rst_stat_read_a: assert property (rd_port |-> PRDATA_O[RESET_STAT_BIT] == $past(USB_RESET_O))
        else $error("reset status bit differs from signalling");
    rsvd_read_a: assert property (rd_port |-> PRDATA_O[15:10] == 6'h00 && PRDATA_O[7:5] == 3'h0)
        else $error("reserved bits not zero");
    pwr_track_a: assert property (rd_port && pwr_ok |-> PRDATA_O[POWER_BIT] == pwr_m)
        else $error("power state bit wrong");
    low_speed_conn_a: assert property (rd_port && PRDATA_O[LOW_SPEED_BIT] |-> PRDATA_O[CCS_BIT])
        else $error("low speed shown while disconnected");
    pwr_quiet_a: assert property (wr_port && !PWDATA_I[RESET_STAT_BIT] && !USB_RESET_O |=> !USB_RESET_O)
        else $error("non reset write moved the reset output");
endmodule

bind root_port_ctrl root_port_checker #(.RESET_CYC(RESET_CYC)) u_chk (
    .CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DEV_CONNECT_I(DEV_CONNECT_I),
    .DEV_LOW_SPEED_I(DEV_LOW_SPEED_I), .USB_RESET_O(USB_RESET_O), .IRQ_O(IRQ_O)
);

// ### tb/usb_dev_model.sv
// Purpose: attached usb device as seen by the port pins
// Assumes: attach and detach are called by the bench
// Notes: speed line is meaningless when detached, so it toggles then
module usb_dev_model (
    input wire logic clk_i,
    input wire logic usb_reset_i,
    output logic connect_o,
    output logic low_speed_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic attached = 1'b0;
    logic speed = 1'b0;
    logic tgl = 1'b0;
    int reset_count = 0;
    // a floating speed line must not look like a steady value
    always @(posedge clk_i) tgl <= ~tgl;
    assign connect_o = attached;
    assign low_speed_o = attached ? speed : tgl;
    always @(posedge usb_reset_i) reset_count++;
    task attach(input logic ls);
        @(posedge clk_i);
        attached <= 1'b1;
        speed <= ls;
    endtask
    task detach();
        @(posedge clk_i);
        attached <= 1'b0;
    endtask
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for the root port status block
// Assumes: short reset signalling count of 8 cycles
// Notes: apb master drives by non-blocking assignment after the edge
module tb import root_port_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, conn, ls, usb_rst, irq;
    logic [31:0] pw [5] = '{32'h100, 32'h0, 32'h200, 32'h300, 32'hfde0};
    logic pe [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    int bad_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    root_port_ctrl #(.RESET_CYC(8)) u_root_port_ctrl (
        .CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .DEV_CONNECT_I(conn), .DEV_LOW_SPEED_I(ls), .USB_RESET_O(usb_rst), .IRQ_O(irq));
    usb_dev_model u_dev (.clk_i(clk), .usb_reset_i(usb_rst), .connect_o(conn), .low_speed_o(ls));
    // ==========================================================
    // tasks
    task end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
        check_count++;
        if ((got & mask) !== (exp & mask)) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; data and error are taken at the pready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] mask);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, mask);
    endtask
    // ==========================================================
    // watchdog, far beyond the roughly two hundred cycles the tests need
    initial begin
        #100us;
        bad_count++;
        end_sim();
    end
    // ==========================================================
    // tests
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(PORT_OFF, 32'h0, '1);
        rdchk(INT_STAT_OFF, 32'h0, '1);
        rdchk(INT_MASK_OFF, 32'h0, '1);
        rdchk(12'h010, 32'h0, '1);
        chk({31'h0, err}, 32'h1, '1);
        apb(1'b1, INT_MASK_OFF, 32'h3);
        u_dev.attach(1'b1);
        repeat (10) @(posedge clk);
        rdchk(PORT_OFF, 32'h0001_0201, '1);
        chk({31'h0, irq}, 32'h1, '1);
        apb(1'b1, PORT_OFF, 32'h0);
        rdchk(PORT_OFF, 32'h0001_0201, '1);
        apb(1'b1, PORT_OFF, 32'h0001_0000);
        rdchk(PORT_OFF, 32'h0000_0201, '1);
        apb(1'b1, INT_STAT_OFF, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0, '1);
        // power set, hold, clear, clear wins, reserved bits ignored
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, PORT_OFF, pw[i]);
            rdchk(PORT_OFF, 32'h201 | (32'(pe[i]) << 8), '1);
            chk({31'h0, usb_rst}, 32'h0, '1);
        end
        apb(1'b1, PORT_OFF, 32'h10);
        @(posedge clk);
        chk({31'h0, usb_rst}, 32'h1, '1);
        rdchk(PORT_OFF, 32'h311, '1);
        for (int n = 0; n < 40 && usb_rst !== 1'b0; n++) @(posedge clk);
        rdchk(PORT_OFF, 32'h301, '1);
        rdchk(INT_STAT_OFF, 32'h2, '1);
        chk({31'h0, irq}, 32'h1, '1);
        chk(32'(u_dev.reset_count), 32'h1, '1);
        apb(1'b1, INT_STAT_OFF, 32'h2);
        u_dev.detach();
        repeat (10) @(posedge clk);
        rdchk(PORT_OFF, 32'h0001_0100, '1);
        apb(1'b1, PORT_OFF, 32'h0001_0000);
        // set enable, suspend and reset on a disconnected port
        for (int b = 1; b < 5; b++) begin
            if (b != 3) begin
                apb(1'b1, PORT_OFF, 32'h1 << b);
                rdchk(PORT_OFF, 32'h0001_0100, '1);
                apb(1'b1, PORT_OFF, 32'h0001_0000);
            end
        end
        chk(32'(u_dev.reset_count), 32'h1, '1);
        apb(1'b1, CFG_OFF, 32'h1);
        apb(1'b1, INT_STAT_OFF, 32'h3);
        u_dev.attach(1'b0);
        repeat (10) @(posedge clk);
        rdchk(PORT_OFF, 32'h1, 32'hffff_feff);
        apb(1'b1, CFG_OFF, 32'h3);
        repeat (4) @(posedge clk);
        rdchk(PORT_OFF, 32'h0001_0000, 32'h0001_0000);
        end_sim();
    end
endmodule
